// [inc/vdop_pkg.sv]
/*
  shared constants, mode encoding and helpers for the video decoder
  output port. assumes a single 125 mhz core clock in every user.
*/
package vdop_pkg;
  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CORE_FREQ_KHZ = 125000;
  localparam int LLC_FREQ_KHZ  = 27000;
  localparam int FIFO_CLK_MIN_KHZ = 20000;
  localparam int FIFO_CLK_MAX_KHZ = 35000;
  localparam int NCO_W = 16;
  // two edge events per line-locked period
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(
    (longint'(LLC_FREQ_KHZ) * 2 * (longint'(1) << NCO_W))
    / CORE_FREQ_KHZ);
  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int PIX_W    = 8;
  localparam int HPOS_W   = 10;
  localparam int LINE_W   = 10;
  localparam int MARGIN_W = 5;
  localparam int GPO_W    = 4;
  localparam int FIFO_AW  = 5;
  localparam int FIFO_DEPTH = 1 << FIFO_AW;
  localparam logic [FIFO_AW:0] FIFO_FULL_LVL = (FIFO_AW+1)'(FIFO_DEPTH);
  localparam logic [FIFO_AW:0] FIFO_HALF_LVL =
    (FIFO_AW+1)'(FIFO_DEPTH / 2);
  localparam logic [LINE_W-1:0] VSYNC_LINES = 10'h006;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2*PIX_W-1:0] RST_PIXEL = 16'h0000;
  localparam logic [GPO_W-1:0]   RST_GPO   = 4'h0;
  localparam logic [NCO_W-1:0]   RST_NCO   = 16'h0000;
  localparam logic [HPOS_W-1:0]  RST_HPOS  = 10'h000;
  localparam logic [FIFO_AW:0]   RST_LEVEL = 6'h00;
  // ----------------------------------------------------------------
  // output modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SYNC  = 2'b00,
    MODE_QUALIFIED_PIXEL_CLOCK  = 2'b01,
    MODE_HALF  = 2'b10,
    MODE_UNDEF = 2'b11
  } vdop_mode_t;

  function automatic logic apply_pol(input logic act, input logic pol);
    apply_pol = act ^ pol;
  endfunction : apply_pol

  // wraps when the end lies before the begin
  function automatic logic in_window(input logic [HPOS_W-1:0] pos,
                                     input logic [HPOS_W-1:0] b,
                                     input logic [HPOS_W-1:0] e);
    if (b <= e) begin
      in_window = (pos >= b) && (pos < e);
    end else begin
      in_window = (pos >= b) || (pos < e);
    end
  endfunction : in_window
endpackage : vdop_pkg

// [design/vdop_clk_gen.sv]
/*
  line-locked clock generator: a phase accumulator makes the 27 mhz
  line-locked clock, its half-rate clock and enable pulses.
  assumes the 125 mhz core clock and a synchronous high reset.
*/
`timescale 1ns/100ps
module vdop_clk_gen (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  output logic      llc_out,
  output logic      llc_rise_out,
  output logic      half_out,
  output logic      half_rise_out
);
  logic [vdop_pkg::NCO_W-1:0] acc;
  logic [vdop_pkg::NCO_W:0]   next_acc;
  logic                       edge_ev;

  assign next_acc = {1'b0, acc} + {1'b0, vdop_pkg::NCO_STEP};
  assign edge_ev  = next_acc[vdop_pkg::NCO_W];

  // jitter of one core period is the price of a single clock domain
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      acc           <= vdop_pkg::RST_NCO;
      llc_out       <= 1'b0;
      llc_rise_out  <= 1'b0;
      half_out      <= 1'b0;
      half_rise_out <= 1'b0;
    end else begin
      acc           <= next_acc[vdop_pkg::NCO_W-1:0];
      llc_out       <= llc_out ^ edge_ev;
      llc_rise_out  <= edge_ev && !llc_out;
      half_rise_out <= edge_ev && !llc_out && !half_out;
      if (edge_ev && !llc_out) begin
        half_out <= !half_out;
      end
    end
  end
endmodule : vdop_clk_gen

// [design/vdop_pin_sync.sv]
/*
  two-stage synchroniser for a pin input with a rising-edge pulse.
  assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/100ps
module vdop_pin_sync (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta;
  logic prev;

  // only the second stage feeds the edge detector
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta      <= 1'b0;
      level_out <= 1'b0;
      prev      <= 1'b0;
    end else begin
      meta      <= pin_in;
      level_out <= meta;
      prev      <= level_out;
    end
  end

  assign rise_out = level_out && !prev;
endmodule : vdop_pin_sync

// [design/vdop_port.sv]
/*
  video decoder output port: pixel bus, sync/active outputs, fifo
  flags, multifunction pin, line-locked clocks, general outputs.
  assumes decoded samples and line/field starts from core logic on the
  same clock; fifo clock arrives asynchronously on a pin.
*/
`timescale 1ns/100ps
module vdop_port (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire logic [1:0]                    output_mode_select_in,
  input  wire logic                          vertical_polarity_bit_in,
  input  wire logic                          horizontal_polarity_bit_in,
  input  wire logic [vdop_pkg::HPOS_W-1:0]   hsync_begin_position_in,
  input  wire logic [vdop_pkg::HPOS_W-1:0]   hsync_end_position_in,
  input  wire logic [vdop_pkg::HPOS_W-1:0]   hactive_begin_in,
  input  wire logic [vdop_pkg::HPOS_W-1:0]   hactive_end_in,
  input  wire logic [vdop_pkg::LINE_W-1:0]   vactive_first_in,
  input  wire logic [vdop_pkg::LINE_W-1:0]   vactive_last_in,
  input  wire logic                          wide_bus_in,
  input  wire logic [vdop_pkg::MARGIN_W-1:0] fifo_margin_field_in,
  input  wire logic                          fifo_flag_polarity_bit_in,
  input  wire logic                          line_qualifier_polarity_bit_in,
  input  wire logic [vdop_pkg::GPO_W-1:0]    general_outputs_in,
  input  wire logic [vdop_pkg::PIX_W-1:0]    luma_in,
  input  wire logic [vdop_pkg::PIX_W-1:0]    chroma_in,
  input  wire logic                          line_start_in,
  input  wire logic                          field_start_in,
  input  wire logic                          genlock_bit_in,
  input  wire logic                          fifo_async_clock_in,
  output logic [2*vdop_pkg::PIX_W-1:0]       pixel_bus_out,
  output logic                               vertical_timing_out,
  output logic                               horizontal_timing_out,
  output logic                               fifo_almost_full_flag_out,
  output logic                               fifo_almost_empty_flag_out,
  output logic                               multifunction_out,
  output logic                               pixel_clock_out,
  output logic                               line_locked_half_clock_out,
  output logic                               line_clock_qualifier_out,
  output logic [vdop_pkg::GPO_W-1:0]         general_outputs_out
);
  // ----------------------------------------------------------------
  // clocks and pin synchronisation
  // ----------------------------------------------------------------
  logic llc;
  logic pix_tick;
  logic half;
  logic half_tick;
  logic fclk_lvl;
  logic fclk_rise;

  vdop_clk_gen u_clk_gen (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .llc_out       (llc),
    .llc_rise_out  (pix_tick),
    .half_out      (half),
    .half_rise_out (half_tick)
  );

  vdop_pin_sync u_fclk_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pin_in      (fifo_async_clock_in),
    .level_out   (fclk_lvl),
    .rise_out    (fclk_rise)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  vdop_pkg::vdop_mode_t mode_eff;
  logic fifo_mode;
  logic launch;

  assign mode_eff = (output_mode_select_in == vdop_pkg::MODE_UNDEF) ?
                    vdop_pkg::MODE_SYNC :
                    vdop_pkg::vdop_mode_t'(output_mode_select_in);
  assign fifo_mode = (mode_eff != vdop_pkg::MODE_SYNC);
  assign launch    = fifo_mode ? fclk_rise : pix_tick;

  // ----------------------------------------------------------------
  // line and field timing
  // ----------------------------------------------------------------
  logic [vdop_pkg::HPOS_W-1:0] hpos;
  logic [vdop_pkg::LINE_W-1:0] line_cnt;
  logic vsync_act;
  logic vact_act;
  logic hsync_act;
  logic hact_act;
  logic next_vert;
  logic next_horz;

  // horizontal position advances once per two line-locked periods
  always_ff @(posedge core_clk_in) begin
    if (rst_in || line_start_in) begin
      hpos <= vdop_pkg::RST_HPOS;
    end else if (half_tick) begin
      hpos <= hpos + 10'h001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || field_start_in) begin
      line_cnt <= '0;
    end else if (line_start_in && line_cnt != '1) begin
      line_cnt <= line_cnt + 10'h001;
    end
  end

  assign vsync_act = line_cnt < vdop_pkg::VSYNC_LINES;
  assign vact_act  = (line_cnt >= vactive_first_in) &&
                     (line_cnt <= vactive_last_in);
  assign hsync_act = vdop_pkg::in_window(hpos, hsync_begin_position_in,
                                         hsync_end_position_in);
  assign hact_act  = vdop_pkg::in_window(hpos, hactive_begin_in,
                                         hactive_end_in);
  assign next_vert = vdop_pkg::apply_pol(fifo_mode ? vact_act : vsync_act,
                                         vertical_polarity_bit_in);
  assign next_horz = vdop_pkg::apply_pol(fifo_mode ? hact_act : hsync_act,
                                         horizontal_polarity_bit_in);

  // ----------------------------------------------------------------
  // pixel formatting and fifo
  // ----------------------------------------------------------------
  logic [2*vdop_pkg::PIX_W-1:0] next_word;
  logic [2*vdop_pkg::PIX_W-1:0] mem [vdop_pkg::FIFO_DEPTH];
  logic [vdop_pkg::FIFO_AW-1:0] wr_ptr;
  logic [vdop_pkg::FIFO_AW-1:0] rd_ptr;
  logic [vdop_pkg::FIFO_AW:0]   level;
  logic [vdop_pkg::FIFO_AW:0]   margin;
  logic wr_en;
  logic rd_en;

  // 8-bit: luma then chroma on the upper byte, lower byte idle
  assign next_word = wide_bus_in ? {luma_in, chroma_in} :
                     {(half ? luma_in : chroma_in), 8'h00};
  assign wr_en  = fifo_mode && pix_tick && (level != vdop_pkg::FIFO_FULL_LVL);
  assign rd_en  = fifo_mode && fclk_rise && (level != vdop_pkg::RST_LEVEL);
  assign margin = {1'b0, fifo_margin_field_in};

  always_ff @(posedge core_clk_in) begin
    if (wr_en) begin
      mem[wr_ptr] <= next_word;
    end
  end

  // leaving the fifo modes flushes; stale words would be out of step
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !fifo_mode) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= vdop_pkg::RST_LEVEL;
    end else begin
      wr_ptr <= wr_ptr + 5'(wr_en);
      rd_ptr <= rd_ptr + 5'(rd_en);
      level  <= level + 6'(wr_en) - 6'(rd_en);
    end
  end

  logic af_act;
  logic ae_act;
  logic hf_act;
  logic next_multi;
  logic qual_phase;
  logic qual_now;
  logic [2*vdop_pkg::PIX_W-1:0] next_pix;

  // an empty fifo holds the bus; unwritten words would show unknowns
  assign next_pix = !fifo_mode ? next_word :
                    rd_en      ? mem[rd_ptr] : pixel_bus_out;

  // one rise per word read; a fill during a high phase adds no edge
  assign qual_now = fclk_rise ? rd_en : qual_phase;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      qual_phase <= 1'b0;
    end else if (fclk_rise) begin
      qual_phase <= rd_en;
    end
  end

  assign af_act = level >= (vdop_pkg::FIFO_FULL_LVL - margin);
  assign ae_act = level <= margin;
  assign hf_act = level >= vdop_pkg::FIFO_HALF_LVL;

  always_comb begin
    case (mode_eff)
      vdop_pkg::MODE_HALF:
        next_multi = vdop_pkg::apply_pol(hf_act,
                                         fifo_flag_polarity_bit_in);
      vdop_pkg::MODE_QUALIFIED_PIXEL_CLOCK:
        next_multi = fclk_lvl && qual_now;
      default:
        next_multi = genlock_bit_in;
    endcase
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pixel_bus_out         <= vdop_pkg::RST_PIXEL;
      vertical_timing_out   <= 1'b0;
      horizontal_timing_out <= 1'b0;
    end else if (launch) begin
      pixel_bus_out         <= next_pix;
      vertical_timing_out   <= next_vert;
      horizontal_timing_out <= next_horz;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fifo_almost_full_flag_out  <= 1'b0;
      fifo_almost_empty_flag_out <= 1'b0;
      multifunction_out          <= 1'b0;
      pixel_clock_out            <= 1'b0;
      line_locked_half_clock_out <= 1'b0;
      line_clock_qualifier_out   <= 1'b0;
      general_outputs_out        <= vdop_pkg::RST_GPO;
    end else begin
      fifo_almost_full_flag_out  <= vdop_pkg::apply_pol(af_act,
                                      fifo_flag_polarity_bit_in);
      fifo_almost_empty_flag_out <= vdop_pkg::apply_pol(ae_act,
                                      fifo_flag_polarity_bit_in);
      multifunction_out          <= next_multi;
      pixel_clock_out            <= fifo_mode ? fclk_lvl : llc;
      line_locked_half_clock_out <= half;
      line_clock_qualifier_out   <= vdop_pkg::apply_pol(half,
                                      line_qualifier_polarity_bit_in);
      general_outputs_out        <= general_outputs_in;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  vsync_lines_a: assert property (
    ($past(launch) && !$past(fifo_mode) &&
     $past(line_cnt) < vdop_pkg::VSYNC_LINES)
      |-> vertical_timing_out != $past(vertical_polarity_bit_in))
    else $error("vsync not active within first six lines");

  vsync_end_a: assert property (
    ($past(launch) && !$past(fifo_mode) &&
     $past(line_cnt) >= vdop_pkg::VSYNC_LINES)
      |-> vertical_timing_out == $past(vertical_polarity_bit_in))
    else $error("vsync active beyond six lines");

  vactive_window_a: assert property (
    ($past(launch) && $past(fifo_mode)) |-> vertical_timing_out ==
      ($past(vact_act) ^ $past(vertical_polarity_bit_in)))
    else $error("vertical active wrong in fifo mode");

  hsync_edge_a: assert property (
    ($past(launch) && !$past(fifo_mode) &&
     $past(hpos) == $past(hsync_begin_position_in) &&
     $past(hsync_begin_position_in) != $past(hsync_end_position_in))
      |-> horizontal_timing_out != $past(horizontal_polarity_bit_in))
    else $error("hsync not asserted at begin position");

  hpos_step_a: assert property (
    (!half_tick && !line_start_in) |=> hpos == $past(hpos))
    else $error("horizontal position moved off the two-clock step");

  almost_full_a: assert property (
    ($past(level) == vdop_pkg::FIFO_FULL_LVL &&
     !$past(fifo_flag_polarity_bit_in))
      |-> fifo_almost_full_flag_out)
    else $error("almost-full missing at full fifo");

  almost_empty_a: assert property (
    ($past(level) == vdop_pkg::RST_LEVEL && !$past(rst_in) &&
     !$past(fifo_flag_polarity_bit_in))
      |-> fifo_almost_empty_flag_out)
    else $error("almost-empty missing at empty fifo");

  sequence half_rise_s;
    $rose(line_locked_half_clock_out);
  endsequence
  half_rate_a: assert property (
    half_rise_s |=> !$rose(line_locked_half_clock_out)[*8])
    else $error("half clock rises too often");

  gpo_follow_a: assert property (
    ##1 general_outputs_out == $past(general_outputs_in))
    else $error("general outputs do not follow");

  undef_mode_a: assert property (
    (output_mode_select_in == 2'b11) |=> multifunction_out ==
      $past(genlock_bit_in))
    else $error("mode 11 not handled as mode 00");

  narrow_bus_a: assert property (
    ($past(launch) && !$past(wide_bus_in)) |-> pixel_bus_out[7:0] == 8'h00)
    else $error("lower byte driven in 8-bit mode");
endmodule : vdop_port

// [dv/vdop_sink.sv]
/*
  downstream video sink model: makes the async fifo clock pin and
  takes words off the pixel bus mid-period, on each pixel clock fall.
  assumes the port under test runs from a 125 mhz core clock.
*/
`timescale 1ns/100ps
module vdop_sink (
  input  wire logic        run_in,
  input  wire logic        fast_in,
  input  wire logic        pixel_clock_in,
  input  wire logic [15:0] pixel_bus_in,
  output logic             fifo_clk_out,
  output int               word_cnt_out,
  output logic [15:0]      word_out
);
  // ----------------------------------------------------------------
  // fifo clock: 35 or 20 mhz, stands low while stopped
  // ----------------------------------------------------------------
  initial begin
    fifo_clk_out = 1'b0;
    forever begin
      if (run_in === 1'b1) begin
        #(fast_in ? 14.3 : 25.0);
        fifo_clk_out = ~fifo_clk_out;
      end else begin
        fifo_clk_out = 1'b0;
        @(run_in);
      end
    end
  end
  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // bus and clock launch on one edge; the fall keeps clear of that race
  initial begin
    word_cnt_out = 0;
    word_out = 16'h0000;
    forever begin
      @(negedge pixel_clock_in);
      word_cnt_out = word_cnt_out + 1;
      word_out = pixel_bus_in;
    end
  end
endmodule : vdop_sink

// [dv/video_decoder_output_port_tb.sv]
/*
  self-checking bench for the video decoder output port: timing,
  pixel bus, fifo flags, multifunction pin, clocks, general outputs.
  assumes the port and the vdop_sink model; no register bus.
*/
`timescale 1ns/100ps
module video_decoder_output_port_tb;
  logic clk, rst, vpol, hpol, wide, fpol, qpol, ls, fs, gl, run, fast;
  logic [1:0]  mode;
  logic [9:0]  hsync_begin_position, hsync_end_position, hab, hae, vaf, val;
  logic [4:0]  margin;
  logic [3:0]  general_outputs, gpo_o;
  logic [7:0]  luma, chroma;
  logic [15:0] pix, word;
  logic        vt, ht, aff, aef, mf, pclk, half, qual, fclk;
  int error_cnt, checked, words, vs, h_hi, r_half, r_pclk, r_mf;
  int q_bad, n_y, n_c;

  vdop_port dut (.core_clk_in(clk), .rst_in(rst),
    .output_mode_select_in(mode), .vertical_polarity_bit_in(vpol),
    .horizontal_polarity_bit_in(hpol), .hsync_begin_position_in(hsync_begin_position),
    .hsync_end_position_in(hsync_end_position), .hactive_begin_in(hab),
    .hactive_end_in(hae), .vactive_first_in(vaf), .vactive_last_in(val),
    .wide_bus_in(wide), .fifo_margin_field_in(margin),
    .fifo_flag_polarity_bit_in(fpol),
    .line_qualifier_polarity_bit_in(qpol), .general_outputs_in(general_outputs),
    .luma_in(luma), .chroma_in(chroma), .line_start_in(ls),
    .field_start_in(fs), .genlock_bit_in(gl),
    .fifo_async_clock_in(fclk), .pixel_bus_out(pix),
    .vertical_timing_out(vt), .horizontal_timing_out(ht),
    .fifo_almost_full_flag_out(aff), .fifo_almost_empty_flag_out(aef),
    .multifunction_out(mf), .pixel_clock_out(pclk),
    .line_locked_half_clock_out(half), .line_clock_qualifier_out(qual),
    .general_outputs_out(gpo_o));

  vdop_sink u_sink (.run_in(run), .fast_in(fast), .pixel_clock_in(pclk),
    .pixel_bus_in(pix), .fifo_clk_out(fclk), .word_cnt_out(words),
    .word_out(word));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi,
                     input int g);
    checked++;
    if (g < lo || g > hi) begin
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      error_cnt++;
    end
  endtask : rng

  // edge and level counts over n cycles, sampled after each edge
  task automatic watch(input int n);
    logic ph, pp, pm;
    r_half = 0; r_pclk = 0; r_mf = 0; h_hi = 0; q_bad = 0;
    n_y = 0; n_c = 0;
    repeat (n) begin
      ph = half; pp = pclk; pm = mf;
      cyc(1);
      r_half += int'(half === 1'b1 && ph === 1'b0);
      r_pclk += int'(pclk === 1'b1 && pp === 1'b0);
      r_mf   += int'(mf === 1'b1 && pm === 1'b0);
      h_hi   += int'(ht === 1'b1);
      q_bad  += int'(qual !== (half ^ qpol));
      n_y    += int'(pix[15:8] === luma);
      n_c    += int'(pix[15:8] === chroma);
    end
  endtask : watch

  // one 200-cycle line; vertical level sampled mid-line
  task automatic line(input logic f);
    ls = 1'b1;
    fs = f;
    cyc(1);
    ls = 1'b0;
    fs = 1'b0;
    watch(100);
    vs += int'(vt === 1'b1);
    cyc(99);
  endtask : line

  task automatic frame();
    vs = 0;
    line(1'b1);
    repeat (9) line(1'b0);
  endtask : frame

  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0; checked = 0; rst = 1'b1; mode = 2'b00;
    vpol = 1'b0; hpol = 1'b0; wide = 1'b1; fpol = 1'b0; qpol = 1'b0;
    ls = 1'b0; fs = 1'b0; gl = 1'b0; run = 1'b0; fast = 1'b1;
    hsync_begin_position = 10'h002; hsync_end_position = 10'h005; hab = 10'h001; hae = 10'h005;
    vaf = 10'h002; val = 10'h004; margin = 5'h04; general_outputs = 4'h0;
    luma = 8'h5a; chroma = 8'h3c;
    cyc(4);
    chk("reset pixel bus", 16'h0000, pix);
    chk("reset outputs", 16'h0000, {7'h00, vt, ht, aff, aef, mf, gpo_o});
    rst = 1'b0;
    foreach (gpo_o[i]) begin
      general_outputs = 4'h1 << i;
      cyc(2);
      chk("general outputs", {12'h000, general_outputs}, {12'h000, gpo_o});
    end
    for (int p = 0; p < 2; p++) begin
      qpol = p[0];
      cyc(3);
      watch(1000);
      rng("half clock rises", 105, 111, r_half);
      rng("line clock rises", 212, 220, r_pclk);
      rng("qualifier mismatches", 0, 0, q_bad);
    end
    cyc(20);
    chk("wide pixel word", 16'h5a3c, pix);
    wide = 1'b0;
    cyc(20);
    watch(40);
    rng("narrow luma samples", 1, 39, n_y);
    rng("narrow samples", 40, 40, n_y + n_c);
    chk("narrow lower byte", 16'h0000, {8'h00, pix[7:0]});
    wide = 1'b1;
    for (int m = 0; m < 4; m += 3) begin
      mode = m[1:0];
      gl = 1'b1;
      cyc(3);
      chk("genlock high", 16'h0001, {15'h0000, mf});
      gl = 1'b0;
      cyc(3);
      chk("genlock low", 16'h0000, {15'h0000, mf});
      frame();
      rng("vsync lines", 6, 6, vs);
      rng("hsync cycles", 24, 32, h_hi);
    end
    vpol = 1'b1;
    hpol = 1'b1;
    frame();
    rng("inverted vsync lines", 4, 4, vs);
    rng("inverted hsync cycles", 68, 76, h_hi);
    vpol = 1'b0;
    hpol = 1'b0;
    run = 1'b1;
    for (int m = 1; m < 3; m++) begin
      mode = m[1:0];
      frame();
      rng("vactive lines", 3, 3, vs);
      rng("hactive cycles", 30, 44, h_hi);
    end
    mode = 2'b01;
    watch(1000);
    rng("fifo clock rises", 275, 285, r_pclk);
    rng("qualified clock rises", 205, 225, r_mf);
    chk("captured word", 16'h5a3c, word);
    run = 1'b0;
    cyc(10);
    vs = words;
    watch(100);
    rng("stopped fifo clock rises", 0, 0, r_pclk);
    rng("stopped captures", vs, vs, words);
    // fifo fills with the far side stalled, then drains fast
    mode = 2'b10;
    cyc(300);
    chk("flags full", 16'h0005, {13'h0000, aff, aef, mf});
    run = 1'b1;
    cyc(700);
    chk("flags empty", 16'h0002, {13'h0000, aff, aef, mf});
    fpol = 1'b1;
    cyc(3);
    chk("flags inverted", 16'h0005, {13'h0000, aff, aef, mf});
    end_of_test();
  end
endmodule : video_decoder_output_port_tb
